/* msm_consts.vh */
`ifndef MSM_CONSTS_VH
`define MSM_CONSTS_VH
// ****************************************
// sfr addresses
// ****************************************
`define MSM_SFR_STK_LO 8'h81
`define MSM_SFR_PTR_LO 8'h82
`define MSM_SFR_PTR_HI 8'h83
`define MSM_SFR_PTR_PG 8'h84
`define MSM_SFR_CFG    8'hAF
`define MSM_SFR_STK_HI 8'hB7
`define MSM_SFR_STATUS 8'hD0
`define MSM_SFR_OPND   8'hE0
`define MSM_SFR_AUX    8'hF0
// ****************************************
// reset values and fields
// ****************************************
`define MSM_STK_RST    8'h07
`define MSM_STATUS_RST 8'h00
`define MSM_ST_HI_RST  7'h00
`define MSM_CFG_XSTK   7
`define MSM_CFG_XRAMEN 0
`define MSM_ST_CARRY   7
`define MSM_ST_HALF    6
`define MSM_ST_SIGNED  2
// ****************************************
// memory map
// ****************************************
`define MSM_CODE_TOP   16'hF7FF
`define MSM_NOP        8'h00
`define MSM_XRAM_TOP   24'h0007FF
`define MSM_BIT_BASE   4'h2
// ****************************************
// data access modes
// ****************************************
`define MSM_M_DIRECT   2'h0
`define MSM_M_INDIR    2'h1
`define MSM_M_REG      2'h2
`define MSM_M_BIT      2'h3
`endif

/* msm_core.v */
// How it works
// - code source follows sampled access pin
// - internal fetches above F7FFH return no-op opcodes
// - lower half direct or indirect, upper indirect
// - status bank bits pick working register bank
// - bytes 20H-2FH reachable as 128 bits
// - stack pointer resets 07H, pre-increments
// - map enable puts 2K xram at bottom
// - addresses above 0007FFH always go external
// - internal xram hits leave pins idle
// - without extension stack wraps FFH to 00H
// - with extension stack continues to 0100H
// - upper xram serves as stack area
// - pointer seen at 81H plus B7H low bits
// - external data address is 24 bits
// - external moves make their own strobes
// - sfr window only by direct or bit addressing
// - three pointer bytes, increment carries to page
// - status word resets 00H, bit addressable
// - second operand register holds mul/div result
// - access pin sampled when reset ends
// - config register at AFH resets 00H
`timescale 1ns/100ps
`include "msm_consts.vh"
module msm_core (
    input  wire        clk_sys_in,                 // core clock
    input  wire        arst_n_in,                  // async reset
    input  wire        external_access_select_in,  // access pin
    input  wire        fetch_req_in,               // fetch strobe
    input  wire [15:0] fetch_addr_in,              // program counter
    output wire [15:0] code_store_addr_out,        // internal store addr
    input  wire [7:0]  code_store_data_in,         // internal store data
    output wire        ext_fetch_out,              // external fetch
    input  wire [7:0]  ext_code_data_in,           // external code
    output reg  [7:0]  code_data_out,              // opcode to core
    output reg         code_valid_out,             // opcode valid
    output reg         fetch_ready_out,            // source chosen
    input  wire        mem_req_in,                 // data access
    input  wire        mem_wr_in,                  // 1 = write
    input  wire [1:0]  mem_mode_in,                // access mode
    input  wire [7:0]  mem_addr_in,                // address
    input  wire [7:0]  mem_wdata_in,               // write data
    output reg  [7:0]  mem_rdata_out,              // read data
    output reg         mem_valid_out,              // read data valid
    input  wire        push_in,                    // push/call
    input  wire [7:0]  push_data_in,               // pushed byte
    input  wire        pop_in,                     // pop/return
    output reg  [7:0]  pop_data_out,               // popped byte
    output reg         pop_valid_out,              // pop data valid
    input  wire        flags_we_in,                // alu flags load
    input  wire [2:0]  flags_in,                   // carry, half carry, signed
    input  wire        muldiv_we_in,               // mul/div result
    input  wire [7:0]  muldiv_b_in,                // second result
    output wire [7:0]  opnd_out,                   // main operand
    output wire [7:0]  b_out,                      // aux operand
    output wire [1:0]  bank_out,                   // active bank
    input  wire        data_pointer_inc_in,                // pointer increment
    output wire [23:0] ptr_out,                    // data pointer
    input  wire        xmove_req_in,               // external move
    input  wire        xmove_wr_in,                // 1 = write
    input  wire [7:0]  xmove_wdata_in,             // move write data
    output reg  [7:0]  xmove_rdata_out,            // move read data
    output reg         xmove_done_out,             // move finished
    output wire        xmove_busy_out,             // move refused
    output reg  [23:0] ext_addr_out,               // external address
    output reg  [7:0]  ext_wdata_out,              // external wdata
    input  wire [7:0]  ext_data_in,                // external rdata
    output reg         ext_rd_n_out,               // read strobe
    output reg         ext_wr_n_out,               // write strobe
    output wire        ext_bus_drive_out           // ports driven
);

// ****************************************
// state
// ****************************************
reg  [7:0]  stk_lo;
reg  [2:0]  stk_hi;
reg  [6:0]  st_hi;
reg  [7:0]  opnd;
reg  [7:0]  b_reg;
reg  [7:0]  ptr_lo;
reg  [7:0]  ptr_hi;
reg  [7:0]  ptr_pg;
reg         cfg_xstk;
reg         cfg_xramen;
reg         int_code_lat;
reg         ext_busy;
reg         ext_wr;
reg  [7:0]  iram [0:255];
reg  [7:0]  xram [0:2047];

// parity is combinational so it never lags the operand
wire        parity = ^opnd;
wire [7:0]  st_word = {st_hi, parity};

assign opnd_out = opnd;
assign b_out    = b_reg;
assign bank_out = st_word[4:3];
assign ptr_out  = {ptr_pg, ptr_hi, ptr_lo};

// ****************************************
// sfr read decode, shared by byte and bit paths
// ****************************************
function [7:0] sfr_rd;
    input [7:0] a;
    begin
        if (a == `MSM_SFR_STK_LO) begin
            sfr_rd = stk_lo;
        end else if (a == `MSM_SFR_STK_HI) begin
            sfr_rd = cfg_xstk ? {5'h00, stk_hi} : 8'h00;
        end else if (a == `MSM_SFR_PTR_LO) begin
            sfr_rd = ptr_lo;
        end else if (a == `MSM_SFR_PTR_HI) begin
            sfr_rd = ptr_hi;
        end else if (a == `MSM_SFR_PTR_PG) begin
            sfr_rd = ptr_pg;
        end else if (a == `MSM_SFR_CFG) begin
            sfr_rd = {cfg_xstk, 6'h00, cfg_xramen};
        end else if (a == `MSM_SFR_STATUS) begin
            sfr_rd = st_word;
        end else if (a == `MSM_SFR_OPND) begin
            sfr_rd = opnd;
        end else if (a == `MSM_SFR_AUX) begin
            sfr_rd = b_reg;
        end else begin
            sfr_rd = 8'h00;                        // unoccupied
        end
    end
endfunction

// ****************************************
// data address resolution
// ****************************************
reg  [7:0]  byte_addr;
reg         to_sfr;
reg  [7:0]  cur_byte;
reg  [7:0]  wbyte;
reg  [7:0]  rd_val;

// each mode picks a byte and a space
always @* begin
    byte_addr = mem_addr_in;
    to_sfr    = 1'b0;
    case (mem_mode_in)
        `MSM_M_DIRECT: begin
            to_sfr = mem_addr_in[7];
        end
        `MSM_M_INDIR: begin
            to_sfr = 1'b0;
        end
        `MSM_M_REG: begin
            byte_addr = {3'h0, st_word[4:3], mem_addr_in[2:0]};
        end
        default: begin
            if (mem_addr_in[7]) begin
                byte_addr = {mem_addr_in[7:3], 3'h0};
                to_sfr    = 1'b1;
            end else begin
                byte_addr = {`MSM_BIT_BASE, mem_addr_in[6:3]};
            end
        end
    endcase
    cur_byte = to_sfr ? sfr_rd(byte_addr) : iram[byte_addr];
    if (mem_mode_in == `MSM_M_BIT) begin
        wbyte  = (cur_byte & ~(8'h01 << mem_addr_in[2:0]))
               | ({7'h00, mem_wdata_in[0]} << mem_addr_in[2:0]);
        rd_val = {7'h00, cur_byte[mem_addr_in[2:0]]};
    end else begin
        wbyte  = mem_wdata_in;
        rd_val = cur_byte;
    end
end

wire        any_we  = mem_req_in & mem_wr_in;
wire        sfr_we  = any_we & to_sfr;
wire        iram_we = any_we & ~to_sfr;

// ****************************************
// stack address
// ****************************************
wire [10:0] stk_full = cfg_xstk ? {stk_hi, stk_lo} : {3'h0, stk_lo};
wire [10:0] stk_sum  = stk_full + 11'h001;
wire [10:0] stk_dif  = stk_full - 11'h001;
// without extension the carry out of the low byte is dropped
wire [10:0] stk_inc  = cfg_xstk ? stk_sum : {3'h0, stk_sum[7:0]};
wire [10:0] stk_dec  = cfg_xstk ? stk_dif : {3'h0, stk_dif[7:0]};
// push writes at the incremented address, pop reads the current one
wire [10:0] stk_addr = push_in ? stk_inc : stk_full;
wire        stk_x    = stk_addr[10:8] != 3'h0;

// ****************************************
// external move decode
// ****************************************
wire [23:0] mv_addr = {ptr_pg, ptr_hi, ptr_lo};
wire        mv_int  = cfg_xramen & (mv_addr <= `MSM_XRAM_TOP);
wire        mv_take = xmove_req_in & ~ext_busy;
assign xmove_busy_out = ext_busy;
// pins only move for external fetches and external data
assign ext_bus_drive_out = ext_busy | ext_fetch_out;

// ****************************************
// memories, no reset on storage
// ****************************************
// iram port: core access wins over a push in the same cycle
always @(posedge clk_sys_in) begin
    if (iram_we) begin
        iram[byte_addr] <= wbyte;
    end else if (push_in & ~stk_x) begin
        iram[stk_addr[7:0]] <= push_data_in;
    end
end

// xram port: stack push has priority over an internal move
always @(posedge clk_sys_in) begin
    if (push_in & stk_x) begin
        xram[stk_addr] <= push_data_in;
    end else if (mv_take & mv_int & xmove_wr_in) begin
        xram[mv_addr[10:0]] <= xmove_wdata_in;
    end
end

// ****************************************
// code fetch source
// ****************************************
// pin level caught on the first edge after release, never by reset
always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        int_code_lat    <= 1'b0;
        fetch_ready_out <= 1'b0;
    end else if (!fetch_ready_out) begin
        int_code_lat    <= external_access_select_in;
        fetch_ready_out <= 1'b1;
    end
end

assign code_store_addr_out = fetch_addr_in;
assign ext_fetch_out = fetch_req_in & fetch_ready_out & ~int_code_lat;

// opcode is registered, one cycle after the request
always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        code_data_out  <= `MSM_NOP;
        code_valid_out <= 1'b0;
    end else begin
        code_valid_out <= fetch_req_in & fetch_ready_out;
        if (!int_code_lat) begin
            code_data_out <= ext_code_data_in;
        end else if (fetch_addr_in > `MSM_CODE_TOP) begin
            code_data_out <= `MSM_NOP;
        end else begin
            code_data_out <= code_store_data_in;
        end
    end
end

// ****************************************
// sfr registers
// ****************************************
always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        stk_lo     <= `MSM_STK_RST;
        stk_hi     <= 3'h0;
        st_hi      <= `MSM_ST_HI_RST;
        opnd       <= 8'h00;
        b_reg      <= 8'h00;
        ptr_lo     <= 8'h00;
        ptr_hi     <= 8'h00;
        ptr_pg     <= 8'h00;
        cfg_xstk   <= 1'b0;
        cfg_xramen <= 1'b0;
    end else begin
        // software write beats a push or pop in the same cycle
        if (sfr_we && byte_addr == `MSM_SFR_STK_LO) begin
            stk_lo <= wbyte;
        end else if (push_in) begin
            stk_lo <= stk_inc[7:0];
        end else if (pop_in) begin
            stk_lo <= stk_dec[7:0];
        end
        // high bits only live while the extension is on
        if (sfr_we && byte_addr == `MSM_SFR_STK_HI && cfg_xstk) begin
            stk_hi <= wbyte[2:0];
        end else if (!cfg_xstk) begin
            stk_hi <= 3'h0;
        end else if (push_in) begin
            stk_hi <= stk_inc[10:8];
        end else if (pop_in) begin
            stk_hi <= stk_dec[10:8];
        end
        if (sfr_we && byte_addr == `MSM_SFR_STATUS) begin
            st_hi <= wbyte[7:1];
        end else if (flags_we_in) begin
            st_hi[`MSM_ST_CARRY - 1]  <= flags_in[2];
            st_hi[`MSM_ST_HALF - 1]   <= flags_in[1];
            st_hi[`MSM_ST_SIGNED - 1] <= flags_in[0];
        end
        if (sfr_we && byte_addr == `MSM_SFR_OPND) begin
            opnd <= wbyte;
        end
        if (sfr_we && byte_addr == `MSM_SFR_AUX) begin
            b_reg <= wbyte;
        end else if (muldiv_we_in) begin
            b_reg <= muldiv_b_in;
        end
        // pointer bytes load alone; increment ripples into page
        if (sfr_we && byte_addr == `MSM_SFR_PTR_LO) begin
            ptr_lo <= wbyte;
        end else if (sfr_we && byte_addr == `MSM_SFR_PTR_HI) begin
            ptr_hi <= wbyte;
        end else if (sfr_we && byte_addr == `MSM_SFR_PTR_PG) begin
            ptr_pg <= wbyte;
        end else if (data_pointer_inc_in) begin
            {ptr_pg, ptr_hi, ptr_lo} <= mv_addr + 24'h000001;
        end
        if (sfr_we && byte_addr == `MSM_SFR_CFG) begin
            cfg_xstk   <= wbyte[`MSM_CFG_XSTK];
            cfg_xramen <= wbyte[`MSM_CFG_XRAMEN];
        end
    end
end

// ****************************************
// read returns
// ****************************************
always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        mem_rdata_out <= 8'h00;
        mem_valid_out <= 1'b0;
        pop_data_out  <= 8'h00;
        pop_valid_out <= 1'b0;
    end else begin
        mem_valid_out <= mem_req_in & ~mem_wr_in;
        mem_rdata_out <= rd_val;
        pop_valid_out <= pop_in & ~push_in;
        pop_data_out  <= stk_x ? xram[stk_addr] : iram[stk_addr[7:0]];
    end
end

// ****************************************
// external move sequencer
// ****************************************
// internal hits finish next cycle; external ones strobe for one cycle
always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
        ext_busy       <= 1'b0;
        ext_wr         <= 1'b0;
        ext_addr_out   <= 24'h000000;
        ext_wdata_out  <= 8'h00;
        ext_rd_n_out   <= 1'b1;
        ext_wr_n_out   <= 1'b1;
        xmove_rdata_out <= 8'h00;
        xmove_done_out  <= 1'b0;
    end else begin
        xmove_done_out <= 1'b0;
        if (ext_busy) begin
            ext_busy       <= 1'b0;
            ext_rd_n_out   <= 1'b1;
            ext_wr_n_out   <= 1'b1;
            xmove_done_out <= 1'b1;
            if (!ext_wr) begin
                xmove_rdata_out <= ext_data_in;
            end
        end else if (mv_take && mv_int) begin
            xmove_done_out <= 1'b1;
            if (!xmove_wr_in) begin
                xmove_rdata_out <= xram[mv_addr[10:0]];
            end
        end else if (mv_take) begin
            ext_busy      <= 1'b1;
            ext_wr        <= xmove_wr_in;
            ext_addr_out  <= mv_addr;
            ext_wdata_out <= xmove_wdata_in;
            ext_rd_n_out  <= xmove_wr_in;
            ext_wr_n_out  <= ~xmove_wr_in;
        end
    end
end

endmodule // msm_core

/* msm_ext_mem.sv */
`timescale 1ns/100ps
// ****************************************
// external program and data memory
// ****************************************
module msm_ext_mem (
    input  wire        clk_sys_in,          // clock
    input  wire [15:0] code_store_addr_out, // fetch addr
    input  wire        ext_fetch_out,       // ext fetch
    input  wire [23:0] ext_addr_out,        // data addr
    input  wire [7:0]  ext_wdata_out,       // wdata
    input  wire        ext_rd_n_out,        // read strobe
    input  wire        ext_wr_n_out,        // write strobe
    output wire [7:0]  code_store_data_in,  // store byte
    output wire [7:0]  ext_code_data_in,    // ext code
    output wire [7:0]  ext_data_in          // ext data
);
    reg [7:0] mem [0:255];
    reg       tick = 1'b0;
    // writes land on the edge that ends the strobe
    always @(posedge clk_sys_in) begin
        tick <= ~tick;
        if (!ext_wr_n_out) begin
            mem[ext_addr_out[7:0]] <= ext_wdata_out;
        end
    end
    // released lines toggle so a stale sample cannot pass for data
    assign ext_data_in = ext_rd_n_out ? {8{tick}} ^ 8'h5A : mem[ext_addr_out[7:0]];
    assign code_store_data_in = code_store_addr_out[7:0] ^ code_store_addr_out[15:8];
    assign ext_code_data_in = ext_fetch_out ? ~code_store_addr_out[7:0] : {8{tick}};
endmodule // msm_ext_mem

/* msm_core_assertions.sv */
`timescale 1ns/100ps
// ****************************************
// port checks
// ****************************************
module msm_core_checker (
    input wire        clk_sys_in,         // clock
    input wire        arst_n_in,          // reset
    input wire        fetch_req_in,       // fetch
    input wire [15:0] fetch_addr_in,      // pc
    input wire [7:0]  code_store_data_in, // store byte
    input wire        ext_fetch_out,      // ext fetch
    input wire [7:0]  ext_code_data_in,   // ext code
    input wire [7:0]  code_data_out,      // opcode
    input wire        code_valid_out,     // opcode valid
    input wire        fetch_ready_out,    // ready
    input wire        mem_req_in,         // access
    input wire        mem_wr_in,          // write
    input wire        mem_valid_out,      // read valid
    input wire        data_pointer_inc_in,        // increment
    input wire [23:0] ptr_out,            // pointer
    input wire        xmove_busy_out,     // busy
    input wire        xmove_done_out,     // done
    input wire [23:0] ext_addr_out,       // ext addr
    input wire        ext_rd_n_out,       // rd strobe
    input wire        ext_wr_n_out,       // wr strobe
    input wire        ext_bus_drive_out   // pins driven
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    // code path: fill above top, otherwise the selected source
    a_nop_fill: assert property (fetch_req_in && fetch_ready_out && !ext_fetch_out
        && fetch_addr_in > 16'hF7FF |=> code_valid_out && code_data_out == 8'h00)
        else $error("no-op fill missing");
    a_internal_code: assert property (fetch_req_in && fetch_ready_out && !ext_fetch_out
        && fetch_addr_in <= 16'hF7FF |=> code_data_out == $past(code_store_data_in))
        else $error("internal code byte wrong");
    a_external_code: assert property (ext_fetch_out
        |=> code_valid_out && code_data_out == $past(ext_code_data_in))
        else $error("external code byte wrong");
    // strobes only while the pins are owned, one cycle each
    a_pins_idle: assert property (!ext_bus_drive_out |-> ext_rd_n_out && ext_wr_n_out)
        else $error("strobe without bus drive");
    a_strobe_pulse: assert property (!(ext_rd_n_out && ext_wr_n_out)
        |-> xmove_busy_out ##1 (ext_rd_n_out && ext_wr_n_out && xmove_done_out))
        else $error("strobe not a single cycle");
    a_move_address: assert property (!ext_rd_n_out || !ext_wr_n_out
        |-> ext_addr_out == ptr_out)
        else $error("external address not pointer");
    a_pointer_carry: assert property (data_pointer_inc_in && !mem_req_in
        |=> ptr_out == $past(ptr_out) + 24'h000001)
        else $error("pointer increment wrong");
    a_read_answer: assert property (mem_req_in && !mem_wr_in |=> mem_valid_out)
        else $error("read not answered");
endmodule // msm_core_checker
bind msm_core msm_core_checker msm_core_checker_inst (.*);

/* test_memory_map_and_stack_logic.sv */
`timescale 1ns/100ps
module test_memory_map_and_stack_logic;
    // ****************************************
    // signals
    // ****************************************
    logic        clk_sys_in = 1'b0, arst_n_in = 1'b0, external_access_select_in = 1'b1;
    logic        fetch_req_in = 1'b0, mem_req_in = 1'b0, mem_wr_in = 1'b0, push_in = 1'b0;
    logic        pop_in = 1'b0, flags_we_in = 1'b0, muldiv_we_in = 1'b0, data_pointer_inc_in = 1'b0;
    logic        xmove_req_in = 1'b0, xmove_wr_in = 1'b0;
    logic [15:0] fetch_addr_in = 16'h0000;
    logic [1:0]  mem_mode_in = 2'h0;
    logic [2:0]  flags_in = 3'h0;
    logic [7:0]  mem_addr_in = 8'h00, mem_wdata_in = 8'h00, push_data_in = 8'h00;
    logic [7:0]  muldiv_b_in = 8'h00, xmove_wdata_in = 8'h00, v, u;
    wire  [15:0] code_store_addr_out;
    wire  [7:0]  code_store_data_in, ext_code_data_in, code_data_out, mem_rdata_out;
    wire  [7:0]  pop_data_out, opnd_out, b_out, xmove_rdata_out, ext_wdata_out, ext_data_in;
    wire         ext_fetch_out, code_valid_out, fetch_ready_out, mem_valid_out, pop_valid_out;
    wire         xmove_done_out, xmove_busy_out, ext_rd_n_out, ext_wr_n_out, ext_bus_drive_out;
    wire  [1:0]  bank_out;
    wire  [23:0] ptr_out, ext_addr_out;
    logic [7:0]  mq[$], cq[$], pq[$], xq[$];
    integer      bad_count = 0, samples_checked = 0, seed = 49;

    msm_core msm_core_inst (.*);
    msm_ext_mem msm_ext_mem_inst (.*);

    // 50 MHz clock
    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // ****************************************
    // tasks
    // ****************************************
    task step;
        @(posedge clk_sys_in);
        #1;
    endtask
    task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_ptr(input string n, input logic [23:0] e, input logic [23:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task rst(input logic pin);
        arst_n_in = 1'b0;
        external_access_select_in = pin;
        repeat (5) step;
        arst_n_in = 1'b1;
        step;
    endtask
    // an idle edge after each request keeps strobes from being set twice in one step
    task xfer(input [1:0] m, input w, input [7:0] a, input [7:0] d);
        mem_req_in = 1'b1;
        mem_mode_in = m;
        mem_wr_in = w;
        mem_addr_in = a;
        mem_wdata_in = d;
        step;
        mem_req_in = 1'b0;
        step;
    endtask
    task wr(input [1:0] m, input [7:0] a, input [7:0] d);
        xfer(m, 1'b1, a, d);
    endtask
    task rd(input [1:0] m, input [7:0] a, input [7:0] e);
        mq.push_back(e);
        xfer(m, 1'b0, a, 8'h00);
    endtask
    task push(input [7:0] d);
        push_in = 1'b1;
        push_data_in = d;
        step;
        push_in = 1'b0;
        step;
    endtask
    task pop(input [7:0] e);
        pq.push_back(e);
        pop_in = 1'b1;
        step;
        pop_in = 1'b0;
        step;
    endtask
    task setp(input [23:0] p);
        wr(0, 8'h84, p[23:16]);
        wr(0, 8'h83, p[15:8]);
        wr(0, 8'h82, p[7:0]);
    endtask
    task xmove(input w, input [7:0] d, input [7:0] e);
        if (!w) xq.push_back(e);
        xmove_req_in = 1'b1;
        xmove_wr_in = w;
        xmove_wdata_in = d;
        step;
        xmove_req_in = 1'b0;
        repeat (3) step;
    endtask
    task fetch(input [15:0] a, input [7:0] e);
        cq.push_back(e);
        fetch_req_in = 1'b1;
        fetch_addr_in = a;
        step;
        fetch_req_in = 1'b0;
        step;
    endtask
    task close_out;
        bad_count = bad_count + mq.size() + cq.size() + pq.size() + xq.size();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // results are compared where settled, half a cycle after the edge
    always @(negedge clk_sys_in) begin
        if (mem_valid_out === 1'b1) chk_byte("mem_rdata", mq.pop_front(), mem_rdata_out);
        if (code_valid_out === 1'b1) chk_byte("code_data", cq.pop_front(), code_data_out);
        if (pop_valid_out === 1'b1) chk_byte("pop_data", pq.pop_front(), pop_data_out);
        if (xmove_done_out === 1'b1 && xq.size() > 0) chk_byte("xmove", xq.pop_front(), xmove_rdata_out);
    end
    // watchdog, far beyond the under two hundred cycles of the sequence
    initial begin
        #(20 * 20000);
        bad_count = bad_count + 1;
        close_out;
    end
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        rst(1'b1);
        rd(0, 8'h81, 8'h07);
        rd(0, 8'hD0, 8'h00);
        rd(0, 8'hAF, 8'h00);
        v = $random(seed);
        push(v);
        rd(0, 8'h81, 8'h08);
        rd(1, 8'h08, v);
        for (int b = 0; b < 4; b++) begin
            v = $random(seed);
            wr(0, 8'hD0, {3'h0, b[1:0], 3'h0});
            chk_byte("bank", b[7:0], {6'h00, bank_out});
            wr(2, 8'h03, v);
            rd(1, {3'h0, b[1:0], 3'h3}, v);
        end
        wr(0, 8'hD0, 8'h00);
        wr(1, 8'h90, v);
        rd(1, 8'h90, v);
        rd(0, 8'h90, 8'h00);
        wr(0, 8'h21, 8'h00);
        wr(3, 8'h0B, 8'h01);
        rd(0, 8'h21, 8'h08);
        rd(3, 8'h0B, 8'h01);
        wr(0, 8'hE0, v);
        chk_byte("opnd", v, opnd_out);
        flags_in = 3'b101;
        flags_we_in = 1'b1;
        step;
        flags_we_in = 1'b0;
        rd(0, 8'hD0, {1'b1, 4'h0, 1'b1, 1'b0, ^v});
        u = ~v;
        muldiv_b_in = u;
        muldiv_we_in = 1'b1;
        step;
        muldiv_we_in = 1'b0;
        rd(0, 8'hF0, u);
        wr(0, 8'hF0, v);
        chk_byte("aux", v, b_out);
        rd(0, 8'hF0, v);
        wr(0, 8'h81, 8'hFF);
        push(u);
        rd(0, 8'h81, 8'h00);
        rd(1, 8'h00, u);
        wr(0, 8'hAF, 8'h80);
        wr(0, 8'h81, 8'hFF);
        push(v);
        rd(0, 8'h81, 8'h00);
        rd(0, 8'hB7, 8'h01);
        pop(v);
        rd(0, 8'hB7, 8'h00);
        rd(0, 8'h81, 8'hFF);
        setp(24'h00FFFF);
        chk_ptr("pointer", 24'h00FFFF, ptr_out);
        data_pointer_inc_in = 1'b1;
        step;
        data_pointer_inc_in = 1'b0;
        step;
        chk_ptr("pointer", 24'h010000, ptr_out);
        wr(0, 8'hAF, 8'h01);
        setp(24'h000010);
        xmove(1'b1, v, 8'h00);
        wr(0, 8'hAF, 8'h00);
        xmove(1'b1, u, 8'h00);
        xmove(1'b0, 8'h00, u);
        wr(0, 8'hAF, 8'h01);
        xmove(1'b0, 8'h00, v);
        setp(24'hA50800);
        xmove(1'b1, u, 8'h00);
        xmove(1'b0, 8'h00, u);
        fetch(16'h1234, 8'h26);
        fetch(16'hF7FF, 8'h08);
        fetch(16'hF800, 8'h00);
        fetch(16'hFFFF, 8'h00);
        rst(1'b0);
        fetch(16'h1234, 8'hCB);
        fetch(16'hF900, 8'hFF);
        rd(0, 8'h81, 8'h07);
        close_out;
    end
endmodule // test_memory_map_and_stack_logic
